// ---- design/swp_cfg.svh ----
// Purpose: constants of the wiper command slave
// Assumes: included by bare name before use
// Notes:   definitions only
`ifndef SWP_CFG_SVH
`define SWP_CFG_SVH

// ----------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------
`define SWP_SLAVE_ADDR   7'h2e
`define SWP_GEN_CALL     7'h00
`define SWP_RW_READ      1'b1
`define SWP_ACK_LVL      1'b0

// ----------------------------------------------------------------
// command and data
// ----------------------------------------------------------------
`define SWP_READ_CMD     8'h00
`define SWP_NO_DATA      8'hff
`define SWP_WIPER_W      7
`define SWP_WIPER_RESET  7'h3f

// ----------------------------------------------------------------
// bit counter positions
// ----------------------------------------------------------------
`define SWP_CNT_ZERO     4'h0
`define SWP_CNT_AFTER_RS 4'h1
`define SWP_CNT_STEP     4'h1
`define SWP_BYTE_LAST    4'h7
`define SWP_ACK_SLOT     4'h8

`endif

// ---- design/swp_cond_det.sv ----
// Purpose: start and stop detection on the synchronised bus
// Assumes: scl and sda already passed two flip-flops
// Notes:   bus_idle_out holds the link logic in reset between frames, except the committed wiper copy and its crossing toggle
`timescale 1ns/100ps
`default_nettype none
module swp_cond_det
  import swp_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     rst_in,
  input  wire swp_bus_t bus_in,
  output logic          bus_idle_out
);

  swp_bus_t prev_q;
  logic     start_w;
  logic     stop_w;

  // ----------------------------------------------------------------
  // conditions
  // ----------------------------------------------------------------
  assign start_w = prev_q.scl & bus_in.scl & prev_q.sda & ~bus_in.sda;
  assign stop_w  = prev_q.scl & bus_in.scl & ~prev_q.sda & bus_in.sda;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_q       <= '1;
      bus_idle_out <= 1'b1;
    end else begin
      prev_q <= bus_in;
      if (stop_w) begin
        bus_idle_out <= 1'b1;
      end else if (start_w) begin
        bus_idle_out <= 1'b0;
      end
    end
  end

endmodule // swp_cond_det
`default_nettype wire

// ---- design/swp_pkg.sv ----
// Purpose: shared types of the wiper command slave
// Assumes: nothing
// Notes:   constants live in swp_cfg.svh
package swp_pkg;

  // ----------------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ADDR   = 3'b000,
    ST_CMD    = 3'b001,
    ST_WDATA  = 3'b010,
    ST_RDATA  = 3'b011,
    ST_IGNORE = 3'b100
  } swp_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } swp_bus_t;

  typedef struct packed {
    logic [7:0] code;
    logic       valid;
  } swp_cmd_t;

endpackage

// ---- design/swp_sync.sv ----
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent level
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none
module swp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule // swp_sync
`default_nettype wire

// ---- design/swp_top.sv ----
// Purpose: serial command slave for a 7-bit volatile wiper
// Assumes: scl is the link clock; master never needs stretching
// Notes:   protocol runs on scl edges, wiper lives on clk_in
//
// Summary of operation
// - accept only write and read commands; code acks any command byte and stores data under any code
// - slave acks address, command, every data byte
// - data byte commits during its ack bit
// - stop or restart mid-byte discards the byte
// - further bytes after each ack update wiper
// - top data bit ignored, seven bits stored
// - stop or restart ends the current command
// - slave acks address; master nacks last byte
// - hold sda through all eight data bits
// - master nack aborts read, sda released
// - non-zero command returns no wiper data
// - 00h zero, 3fh mid, 7fh full scale
// - code n selects tap n, 128 taps
// - power or brownout reset loads mid-scale
// - answer only own fixed seven-bit address
// - general call never acked, then ignored
// - malformed traffic aborted before register corruption
`include "swp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module swp_top
  import swp_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    scl_link_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n_out,
  output logic [`SWP_WIPER_W-1:0]      wiper_tap_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [6:0] addr);
    addr_match = (addr == `SWP_SLAVE_ADDR) && (addr != `SWP_GEN_CALL);
  endfunction

  function automatic logic [7:0] read_byte(input swp_cmd_t cmd, input logic [`SWP_WIPER_W-1:0] wiper);
    read_byte = (cmd.valid && (cmd.code == `SWP_READ_CMD)) ? {1'b0, wiper} : `SWP_NO_DATA;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]                 bus_raw_w;
  swp_bus_t                   bus_sync_w;
  logic                       bus_idle_w;
  logic                       link_por_q;
  logic                       tog_sync_w;
  logic                       tog_seen_q;
  logic                       commit_clk_w;
  logic [`SWP_WIPER_W-1:0]    wiper_q;
  logic                       sda_out_q;

  swp_state_t                 st_q;
  swp_state_t                 st_d;
  logic [3:0]                 cnt_q;
  logic [3:0]                 cnt_d;
  logic [6:0]                 shift_q;
  logic [6:0]                 shift_d;
  logic [7:0]                 tx_q;
  logic [7:0]                 tx_d;
  swp_cmd_t                   cmd_q;
  swp_cmd_t                   cmd_d;
  logic                       rd_first_q;
  logic                       rd_first_d;
  logic                       pend_q;
  logic                       pend_d;
  logic [`SWP_WIPER_W-1:0]    data_q;
  logic [`SWP_WIPER_W-1:0]    data_d;
  logic                       low_q;
  logic                       low_d;
  logic                       sda_rise_q;

  logic                       restart_q;
  logic                       restart_w;
  logic                       sda_oe_n_q;

  logic [`SWP_WIPER_W-1:0]    shadow_q;
  logic                       commit_tog_q;

  logic [7:0]                 byte_w;
  logic                       last_bit_w;
  logic                       ack_bit_w;
  logic                       addr_hit_w;
  logic                       rd_req_w;
  logic                       master_ack_w;
  logic                       commit_w;
  logic [7:0]                 tx_load_w;

  // ----------------------------------------------------------------
  // system clock side: bus watch and wiper register
  // ----------------------------------------------------------------
  assign bus_raw_w = {scl_link_in, sda_in};

  swp_sync #(
    .WIDTH (2)
  ) u_bus_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (bus_raw_w),
    .q_out  (bus_sync_w)
  );

  // frame boundaries reset the link logic, except the committed wiper copy and its crossing toggle
  swp_cond_det u_cond_det (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .bus_in       (bus_sync_w),
    .bus_idle_out (bus_idle_w)
  );

  swp_sync #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (commit_tog_q),
    .q_out  (tog_sync_w)
  );

  assign commit_clk_w = tog_sync_w ^ tog_seen_q;

  always_ff @(posedge clk_in) begin
    link_por_q <= rst_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tog_seen_q <= 1'b0;
      wiper_q    <= `SWP_WIPER_RESET;
      sda_out_q  <= 1'b0;
    end else begin
      tog_seen_q <= tog_sync_w;
      sda_out_q  <= 1'b0;
      if (commit_clk_w) begin
        wiper_q <= shadow_q;
      end
    end
  end

  assign sda_out       = sda_out_q;
  assign sda_oe_n_out  = sda_oe_n_q;
  assign wiper_tap_out = wiper_q;

  // ----------------------------------------------------------------
  // link side: decode of the bit in flight
  // ----------------------------------------------------------------
  assign byte_w       = {shift_q, sda_in};
  assign last_bit_w   = (cnt_q == `SWP_BYTE_LAST);
  assign ack_bit_w    = (cnt_q == `SWP_ACK_SLOT);
  assign addr_hit_w   = addr_match(byte_w[7:1]);
  assign rd_req_w     = (byte_w[0] == `SWP_RW_READ);
  assign master_ack_w = (sda_in == `SWP_ACK_LVL);
  assign commit_w     = ack_bit_w & pend_q & ~restart_q;
  assign tx_load_w    = read_byte(cmd_q, shadow_q);
  assign restart_w    = sda_rise_q & ~sda_in;

  // ----------------------------------------------------------------
  // link side: command state machine
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q + `SWP_CNT_STEP;
    shift_d    = {shift_q[5:0], sda_in};
    tx_d       = tx_q;
    cmd_d      = cmd_q;
    rd_first_d = rd_first_q;
    pend_d     = pend_q;
    data_d     = data_q;
    low_d      = 1'b0;
    if (restart_q) begin
      st_d       = ST_ADDR;
      cnt_d      = `SWP_CNT_AFTER_RS;
      shift_d    = {6'h00, sda_in};
      pend_d     = 1'b0;
      rd_first_d = 1'b0;
    end else if (last_bit_w) begin
      case (st_q)
        ST_ADDR: begin
          if (!addr_hit_w) begin
            st_d = ST_IGNORE;
          end else begin
            low_d      = 1'b1;
            st_d       = rd_req_w ? ST_RDATA : ST_CMD;
            rd_first_d = rd_req_w;
          end
        end
        ST_CMD: begin
          cmd_d.code  = byte_w;
          cmd_d.valid = 1'b1;
          st_d        = ST_WDATA;
          low_d       = 1'b1;
        end
        ST_WDATA: begin
          data_d = byte_w[6:0];
          pend_d = 1'b1;
          low_d  = 1'b1;
        end
        default: begin
          low_d = 1'b0;
        end
      endcase
    end else if (ack_bit_w) begin
      cnt_d  = `SWP_CNT_ZERO;
      pend_d = 1'b0;
      if (st_q == ST_RDATA) begin
        if (rd_first_q || master_ack_w) begin
          tx_d       = tx_load_w;
          low_d      = ~tx_load_w[7];
          rd_first_d = 1'b0;
        end else begin
          st_d = ST_IGNORE;
        end
      end
    end else if (st_q == ST_RDATA) begin
      low_d = ~tx_q[6];
      tx_d  = {tx_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // link side: rising edge registers
  // ----------------------------------------------------------------
  always_ff @(posedge scl_link_in or posedge bus_idle_w) begin
    if (bus_idle_w) begin
      st_q       <= ST_ADDR;
      cnt_q      <= `SWP_CNT_ZERO;
      shift_q    <= 7'h00;
      tx_q       <= 8'h00;
      cmd_q      <= '0;
      rd_first_q <= 1'b0;
      pend_q     <= 1'b0;
      data_q     <= 7'h00;
      low_q      <= 1'b0;
      sda_rise_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      shift_q    <= shift_d;
      tx_q       <= tx_d;
      cmd_q      <= cmd_d;
      rd_first_q <= rd_first_d;
      pend_q     <= pend_d;
      data_q     <= data_d;
      low_q      <= low_d;
      sda_rise_q <= sda_in;
    end
  end

  // ----------------------------------------------------------------
  // link side: committed wiper copy and crossing toggle
  // ----------------------------------------------------------------
  always_ff @(posedge scl_link_in or posedge link_por_q) begin
    if (link_por_q) begin
      shadow_q     <= `SWP_WIPER_RESET;
      commit_tog_q <= 1'b0;
    end else if (commit_w) begin
      shadow_q     <= data_q;
      commit_tog_q <= ~commit_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // link side: falling edge, restart watch and sda drive
  // ----------------------------------------------------------------
  always_ff @(negedge scl_link_in or posedge bus_idle_w) begin
    if (bus_idle_w) begin
      restart_q  <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      restart_q  <= restart_w;
      sda_oe_n_q <= ~low_q | restart_w;
    end
  end

endmodule // swp_top
`default_nettype wire

// ---- sim/swp_bus_master.sv ----
// Purpose: behavioural bus master facing the wiper slave
// Assumes: sda has a pull-up; scl stands still between frames
// Notes:   start and stop use slow phases
`timescale 1ns/100ps
`default_nettype none
module swp_bus_master
  import swp_pkg::*;
(
  input  wire logic    sda_in,
  output var swp_bus_t bus_out
);
  initial bus_out = 2'b11;

  // change sda mid low phase, sample at scl rise
  task automatic m_bit(input logic b, output logic r);
    #45 bus_out.sda = b;
    #60 bus_out.scl = 1'b1;
    r = sda_in;
    #15 bus_out.scl = 1'b0;
  endtask

  // start or restart
  task automatic m_start();
    #45 bus_out.sda = 1'b1;
    #60 bus_out.scl = 1'b1;
    #200 bus_out.sda = 1'b0;
    #200 bus_out.scl = 1'b0;
  endtask

  task automatic m_stop();
    #45 bus_out.sda = 1'b0;
    #60 bus_out.scl = 1'b1;
    #200 bus_out.sda = 1'b1;
    #200;
  endtask

  // byte msb first, released for the ack slot
  task automatic m_wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) m_bit(b[i], r);
    m_bit(1'b1, ack);
  endtask

  // master acks all but the last byte
  task automatic m_rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      m_bit(1'b1, r);
      d[i] = r;
    end
    m_bit(nack, r);
  endtask
endmodule // swp_bus_master
`default_nettype wire

// ---- sim/swp_wiper_props.sv ----
// Purpose: concurrent checks on the wiper slave ports
// Assumes: bound to swp_top
// Notes:   one clk_in domain
`include "swp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module swp_wiper_props (
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic                    scl_link_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe_n_out,
  input wire logic [`SWP_WIPER_W-1:0] wiper_tap_out
);
  logic [6:0] low_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // length of the current low drive on sda
  always_ff @(posedge clk_in) begin
    if (rst_in || sda_oe_n_out) begin
      low_q <= 7'h00;
    end else if (low_q != 7'h7f) begin
      low_q <= low_q + 7'h01;
    end
  end

  drive_zero_a: assert property (sda_out == 1'b0)
    else $error("sda output value not zero");
  reset_mid_a: assert property (disable iff (1'b0) rst_in |=> wiper_tap_out == 7'h3f)
    else $error("wiper not mid-scale after reset");
  oe_reset_a: assert property (disable iff (1'b0) rst_in [*3] |-> sda_oe_n_out)
    else $error("sda driven during reset");
  oe_low_phase_a: assert property ($changed(sda_oe_n_out) |-> !scl_link_in)
    else $error("sda drive changed while scl high");
  wiper_ack_a: assert property ($changed(wiper_tap_out) |->
    !$past(sda_oe_n_out, 4) || !$past(sda_oe_n_out, 5) || !$past(sda_oe_n_out, 6))
    else $error("wiper changed outside an ack slot");
  idle_stable_a: assert property (scl_link_in [*8] |-> $stable(wiper_tap_out))
    else $error("wiper changed while bus clock idle");
  hold_bound_a: assert property (low_q < 7'h3c)
    else $error("sda held low beyond one byte");
  slot_hold_a: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*3])
    else $error("sda drive shorter than a bit slot");

  cover property ($changed(wiper_tap_out));
  cover property ($fell(sda_oe_n_out));
  cover property (low_q == 7'h0a);
endmodule // swp_wiper_props

bind swp_top swp_wiper_props chk_u (.clk_in(clk_in), .rst_in(rst_in), .scl_link_in(scl_link_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .wiper_tap_out(wiper_tap_out));
`default_nettype wire

// ---- sim/tb_smbus_cmd_wiper_slave.sv ----
// Purpose: self-checking bench of the wiper slave
// Assumes: master model drives the bus
// Notes:   expected values queued, compared by a monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(o, e) begin exp_q.push_back(8'(e)); obs_v = 8'(o); ->smp_ev; #1; end
module tb_smbus_cmd_wiper_slave;
  import swp_pkg::*;
  logic       clk_in, rst_in, sda_out, sda_oe_n_out, a;
  logic [6:0] wiper_tap_out;
  logic [7:0] d, lfsr_q, obs_v, e_v;
  logic [7:0] exp_q[$];
  int         miscompares = 0;
  int         check_count = 0;
  int         cyc = 0;
  swp_bus_t   bus;
  wire logic  sda_w = bus.sda & (sda_oe_n_out | sda_out);
  event       smp_ev;

  swp_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .scl_link_in(bus.scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .wiper_tap_out(wiper_tap_out));
  swp_bus_master m_u (.sda_in(sda_w), .bus_out(bus));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(smp_ev) begin
    check_count++;
    e_v = exp_q.pop_front();
    if (obs_v !== e_v) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, obs_v, e_v);
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    #1 rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    `CHK(wiper_tap_out, 7'h3f)
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] x);
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    `CHK(a, 1'b0)
    m_u.m_wbyte(c, a);
    `CHK(a, 1'b0)
    m_u.m_wbyte(x, a);
    `CHK(a, 1'b0)
    m_u.m_stop();
    `CHK(wiper_tap_out, x[6:0])
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] x);
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    m_u.m_wbyte(c, a);
    m_u.m_start();
    m_u.m_wbyte(8'h5d, a);
    `CHK(a, 1'b0)
    m_u.m_rbyte(1'b1, d);
    `CHK(d, x)
    m_u.m_stop();
    `CHK(sda_oe_n_out, 1'b1)
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    rst_in = 1'b1;
    lfsr_q = 8'h4c;
    do_reset();
    wr(8'h00, 8'hc5);
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    m_u.m_wbyte(8'h00, a);
    m_u.m_wbyte(8'h00, a);
    #100 `CHK(wiper_tap_out, 7'h00)
    m_u.m_wbyte(8'hff, a);
    #100 `CHK(wiper_tap_out, 7'h7f)
    m_u.m_stop();
    rd(8'h00, 8'h7f);
    rd(8'h01, 8'hff);
    m_u.m_start();
    m_u.m_wbyte(8'h5e, a);
    `CHK(a, 1'b1)
    m_u.m_start();
    m_u.m_wbyte(8'h00, a);
    `CHK(a, 1'b1)
    m_u.m_wbyte(8'h11, a);
    `CHK(a, 1'b1)
    m_u.m_stop();
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    m_u.m_wbyte(8'h00, a);
    repeat (3) m_u.m_bit(1'b0, a);
    m_u.m_stop();
    `CHK(wiper_tap_out, 7'h7f)
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    m_u.m_wbyte(8'h00, a);
    repeat (4) m_u.m_bit(1'b0, a);
    m_u.m_start();
    m_u.m_wbyte(8'h5c, a);
    `CHK(a, 1'b0)
    m_u.m_stop();
    `CHK(wiper_tap_out, 7'h7f)
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      wr(8'h00, lfsr_q);
      rd(8'h00, {1'b0, lfsr_q[6:0]});
    end
    do_reset();
    end_sim();
  end
endmodule // tb_smbus_cmd_wiper_slave
`default_nettype wire
